// ### rtl/pmbus_target_interface.v
// Contract
// - Serve 100 kHz, 400 kHz and 1 MHz clocks
// - Never stretch during the address byte
// - May stretch after command byte bit 0
// - Stretch after read address bit 0
// - Stretch before acknowledging final data byte
// - Long blocks: hold between bits 1, 0
// - Extra checksum clocks mean checksum in use
// - Require-checksum option rejects unchecked writes
// - Alerting: answer alert address with own address
// - Persistent non-communication fault re-raises alert
// - Only store-all commits settings to memory
// - Override picks strap or stored defaults
// - Address from select pin, 0x10 to 0x2F
// - Programming mode: answer bus, no conversion
module pmbus_target_interface (
    // Clock and reset
    input wire core_clk_i,
    input wire rst_n_i,
    // Bus pins
    input wire bus_clock_pin_i,
    output wire bus_clock_pin_o,
    output wire bus_clock_pin_oe_o,
    input wire bus_data_pin_i,
    output wire bus_data_pin_o,
    output wire bus_data_pin_oe_o,
    output wire alert_output_pin_o,
    output wire alert_output_pin_oe_o,
    // Straps and options
    input wire [4:0] address_select_pin_i,
    input wire strap_versus_nvm_select_i,
    input wire require_pec_i,
    input wire [7:0] wr_len_i,
    output wire [6:0] own_addr_o,
    output wire use_strap_defaults_o,
    // Command port
    output reg wr_byte_o,
    output reg [7:0] wr_data_o,
    output reg wr_first_o,
    input wire byte_ready_i,
    output reg wr_commit_o,
    output reg wr_reject_o,
    output reg pec_used_o,
    output reg pec_error_o,
    output reg nvm_store_o,
    output reg rd_req_o,
    input wire [7:0] rd_data_i,
    input wire rd_valid_i,
    output wire [7:0] pec_crc_o,
    // Faults
    input wire fault_event_i,
    input wire noncml_fault_i,
    // Power state
    input wire internal_bias_5v_ok_i,
    input wire analog_input_rail_ok_i,
    input wire power_input_rail_ok_i,
    input wire conversion_request_i,
    output wire conversion_enable_o,
    output wire programming_mode_o
);
`include "pmbus_target_map.vh"

    localparam integer SU_INT = `DATA_SU_CYC;
    localparam [3:0] SU_CYC = SU_INT[3:0];

    reg scl_s1_r, scl_s2_r, scl_d_r;
    reg sda_s1_r, sda_s2_r, sda_d_r;
    reg [2:0] state_r;
    reg [3:0] bit_cnt_r;
    reg [7:0] shift_r;
    reg [7:0] tx_r;
    reg [7:0] crc_r;
    reg [7:0] byte_cnt_r;
    reg [7:0] cmd_r;
    reg is_read_r, is_ara_r, sda_oe_r, scl_oe_r, hold_r, go_r, acked_r;
    reg [1:0] wait_r;
    reg [3:0] su_cnt_r;
    reg init_r, alert_r;
    reg [6:0] own_addr_r;
    reg strap_sel_r;
    wire scl_rise = scl_s2_r & ~scl_d_r;
    wire scl_fall = ~scl_s2_r & scl_d_r;
    wire start_c = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
    wire stop_c = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
    wire [7:0] rx_byte = {shift_r[6:0], sda_s2_r};
    wire [7:0] tx_load = is_ara_r ? {own_addr_r, 1'b0} : rd_data_i;
    // Whole byte already sits in shift_r when the eighth clock falls
    wire addr_own = (shift_r[7:1] == own_addr_r);
    wire addr_ara = (shift_r[7:1] == `ADDR_ALERT_RESP) & shift_r[0] & alert_r;
    wire blk_fourth = (byte_cnt_r > 8'h04) & (byte_cnt_r[1:0] == 2'h0);
    wire pec_seen = (byte_cnt_r == wr_len_i + 8'h01);
    wire [7:0] crc_in = (hold_r & wait_r != `WAIT_BYTE) ? tx_load : shift_r;
    wire [7:0] crc_nxt;
    wire ara_done = hold_r & go_r & is_ara_r & (su_cnt_r == 4'h0);
    reg hold_go;

    crc8_byte u_crc (
        .crc_i(crc_r),
        .data_i(crc_in),
        .crc_o(crc_nxt)
    );

    always @* begin
        case (wait_r)
            `WAIT_BYTE: hold_go = byte_ready_i;
            `WAIT_RDATA: hold_go = rd_valid_i;
            `WAIT_MID: hold_go = byte_ready_i;
            default: hold_go = 1'b1;
        endcase
    end

    // Open-drain: only ever pull low
    assign bus_clock_pin_o = 1'b0;
    assign bus_data_pin_o = 1'b0;
    assign alert_output_pin_o = 1'b0;
    assign bus_clock_pin_oe_o = scl_oe_r;
    assign bus_data_pin_oe_o = sda_oe_r;
    assign alert_output_pin_oe_o = alert_r;
    assign own_addr_o = own_addr_r;
    assign use_strap_defaults_o = strap_sel_r;
    assign pec_crc_o = crc_r;
    // Bus stays alive on bias and analog rail; switching needs the power rail too
    assign programming_mode_o = internal_bias_5v_ok_i & analog_input_rail_ok_i
        & ~power_input_rail_ok_i;
    assign conversion_enable_o = conversion_request_i & internal_bias_5v_ok_i
        & analog_input_rail_ok_i & power_input_rail_ok_i;

    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_s1_r <= bus_clock_pin_i;
            scl_s2_r <= scl_s1_r;
            scl_d_r <= scl_s2_r;
            sda_s1_r <= bus_data_pin_i;
            sda_s2_r <= sda_s1_r;
            sda_d_r <= sda_s2_r;
        end
    end

    // Straps caught once, just after reset release
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            init_r <= 1'b0;
            own_addr_r <= `ADDR_BASE;
            strap_sel_r <= 1'b0;
        end else if (!init_r) begin
            init_r <= 1'b1;
            own_addr_r <= `ADDR_BASE + {2'h0, address_select_pin_i};
            strap_sel_r <= strap_versus_nvm_select_i;
        end
    end

    // New fault wins over the clear from an alert answer
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            alert_r <= 1'b0;
        end else if (fault_event_i | (ara_done & noncml_fault_i)) begin
            alert_r <= 1'b1;
        end else if (ara_done) begin
            alert_r <= 1'b0;
        end
    end

    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= `ST_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            tx_r <= 8'h00;
            crc_r <= `CRC_INIT;
            byte_cnt_r <= 8'h00;
            cmd_r <= 8'h00;
            is_read_r <= 1'b0;
            is_ara_r <= 1'b0;
            sda_oe_r <= 1'b0;
            scl_oe_r <= 1'b0;
            hold_r <= 1'b0;
            go_r <= 1'b0;
            acked_r <= 1'b0;
            wait_r <= `WAIT_BYTE;
            su_cnt_r <= 4'h0;
            wr_byte_o <= 1'b0;
            wr_data_o <= 8'h00;
            wr_first_o <= 1'b0;
            wr_commit_o <= 1'b0;
            wr_reject_o <= 1'b0;
            pec_used_o <= 1'b0;
            pec_error_o <= 1'b0;
            nvm_store_o <= 1'b0;
            rd_req_o <= 1'b0;
        end else begin
            wr_byte_o <= 1'b0;
            wr_commit_o <= 1'b0;
            wr_reject_o <= 1'b0;
            nvm_store_o <= 1'b0;
            rd_req_o <= 1'b0;
            if (!init_r) begin
                state_r <= `ST_IDLE;
            end else if (start_c) begin
                if (state_r == `ST_IDLE || state_r == `ST_SKIP) begin
                    crc_r <= `CRC_INIT;
                    byte_cnt_r <= 8'h00;
                end
                state_r <= `ST_ADDR;
                bit_cnt_r <= 4'h0;
                sda_oe_r <= 1'b0;
                scl_oe_r <= 1'b0;
                hold_r <= 1'b0;
            end else if (stop_c) begin
                // Checksum clocks are the only sign of checksum use
                if (!is_read_r && byte_cnt_r != 8'h00 && state_r != `ST_SKIP) begin
                    pec_used_o <= pec_seen;
                    pec_error_o <= pec_seen & (crc_r != 8'h00);
                    if ((pec_seen && crc_r == 8'h00)
                        || (byte_cnt_r == wr_len_i && !require_pec_i)) begin
                        wr_commit_o <= 1'b1;
                        nvm_store_o <= (cmd_r == `CMD_STORE_ALL);
                    end else begin
                        wr_reject_o <= 1'b1;
                    end
                end
                state_r <= `ST_IDLE;
                sda_oe_r <= 1'b0;
                scl_oe_r <= 1'b0;
                hold_r <= 1'b0;
            end else if (hold_r) begin
                // Clock held low; present data, wait setup, then let go
                if (!go_r && hold_go) begin
                    go_r <= 1'b1;
                    su_cnt_r <= SU_CYC;
                    if (wait_r == `WAIT_BYTE) begin
                        sda_oe_r <= 1'b1;
                        state_r <= `ST_RXACK;
                    end else if (wait_r != `WAIT_MID) begin
                        tx_r <= tx_load;
                        crc_r <= crc_nxt;
                        if (state_r == `ST_TXACK) begin
                            sda_oe_r <= ~tx_load[7];
                            bit_cnt_r <= 4'h0;
                            state_r <= `ST_TX;
                        end else begin
                            sda_oe_r <= 1'b1;
                            state_r <= `ST_RXACK;
                        end
                    end
                end else if (go_r && su_cnt_r != 4'h0) begin
                    su_cnt_r <= su_cnt_r - 4'h1;
                end else if (go_r) begin
                    scl_oe_r <= 1'b0;
                    hold_r <= 1'b0;
                    go_r <= 1'b0;
                end
            end else begin
                case (state_r)
                    `ST_ADDR, `ST_RX: begin
                        if (scl_rise) begin
                            shift_r <= rx_byte;
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end else if (scl_fall && bit_cnt_r == 4'h7 && state_r == `ST_RX
                                     && blk_fourth && !byte_ready_i) begin
                            scl_oe_r <= 1'b1;
                            hold_r <= 1'b1;
                            wait_r <= `WAIT_MID;
                        end else if (scl_fall && bit_cnt_r == 4'h8) begin
                            bit_cnt_r <= 4'h0;
                            if (state_r == `ST_ADDR) begin
                                is_ara_r <= addr_ara;
                                is_read_r <= shift_r[0];
                                if (!addr_own && !addr_ara) begin
                                    state_r <= `ST_SKIP;
                                end else if (!shift_r[0]) begin
                                    crc_r <= crc_nxt;
                                    sda_oe_r <= 1'b1;
                                    state_r <= `ST_RXACK;
                                end else begin
                                    crc_r <= crc_nxt;
                                    scl_oe_r <= 1'b1;
                                    hold_r <= 1'b1;
                                    wait_r <= addr_ara ? `WAIT_NONE : `WAIT_RDATA;
                                    rd_req_o <= ~addr_ara;
                                end
                            end else begin
                                crc_r <= crc_nxt;
                                byte_cnt_r <= byte_cnt_r + 8'h01;
                                if (byte_cnt_r == 8'h00) begin
                                    cmd_r <= shift_r;
                                end
                                wr_byte_o <= 1'b1;
                                wr_data_o <= shift_r;
                                wr_first_o <= (byte_cnt_r == 8'h00);
                                scl_oe_r <= 1'b1;
                                hold_r <= 1'b1;
                                wait_r <= `WAIT_BYTE;
                            end
                        end
                    end
                    `ST_RXACK: begin
                        if (scl_fall) begin
                            bit_cnt_r <= 4'h0;
                            if (is_read_r) begin
                                sda_oe_r <= ~tx_r[7];
                                state_r <= `ST_TX;
                            end else begin
                                sda_oe_r <= 1'b0;
                                state_r <= `ST_RX;
                            end
                        end
                    end
                    `ST_TX: begin
                        if (scl_rise) begin
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end else if (scl_fall && bit_cnt_r == 4'h8) begin
                            sda_oe_r <= 1'b0;
                            state_r <= `ST_TXACK;
                        end else if (scl_fall) begin
                            sda_oe_r <= ~tx_r[~bit_cnt_r[2:0]];
                        end
                    end
                    `ST_TXACK: begin
                        if (scl_rise) begin
                            acked_r <= ~sda_s2_r;
                        end else if (scl_fall && acked_r && !is_ara_r) begin
                            rd_req_o <= 1'b1;
                            scl_oe_r <= 1'b1;
                            hold_r <= 1'b1;
                            wait_r <= `WAIT_RDATA;
                        end else if (scl_fall) begin
                            state_r <= `ST_SKIP;
                        end
                    end
                    default: begin
                        sda_oe_r <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule

// ### rtl/pmbus_target_map.vh
`ifndef PMBUS_TARGET_MAP_VH
`define PMBUS_TARGET_MAP_VH

// Bus addressing
`define ADDR_BASE 7'h10
`define ADDR_ALERT_RESP 7'h0C

// Command codes the block itself reacts to
`define CMD_STORE_ALL 8'h15

// Checksum x^8+x^2+x+1
`define CRC_POLY 8'h07
`define CRC_INIT 8'h00

// Bus rates served, in kHz
`define RATE_STD_KHZ 100
`define RATE_FAST_KHZ 400
`define RATE_FASTPLUS_KHZ 1000

// Data setup before the clock is let go, at the fastest rate
`define CORE_CLK_NS 10
`define DATA_SU_NS 50
`define DATA_SU_CYC ((`DATA_SU_NS + `CORE_CLK_NS - 1) / `CORE_CLK_NS)

// Target states
`define ST_IDLE 3'h0
`define ST_ADDR 3'h1
`define ST_RX 3'h2
`define ST_RXACK 3'h3
`define ST_TX 3'h4
`define ST_TXACK 3'h5
`define ST_SKIP 3'h6

// What a clock hold waits for
`define WAIT_BYTE 2'h0
`define WAIT_RDATA 2'h1
`define WAIT_NONE 2'h2
`define WAIT_MID 2'h3

`endif

// ### rtl/crc8_byte.v
module crc8_byte (
    // Running checksum
    input wire [7:0] crc_i,
    input wire [7:0] data_i,
    output reg [7:0] crc_o
);
`include "pmbus_target_map.vh"

    integer i;

    always @* begin
        crc_o = crc_i ^ data_i;
        for (i = 0; i < 8; i = i + 1) begin
            crc_o = crc_o[7] ? ({crc_o[6:0], 1'b0} ^ `CRC_POLY) : {crc_o[6:0], 1'b0};
        end
    end

endmodule

// ### test/pmbus_target_interface_chk.sv
module pmbus_target_interface_chk (
    // Clock and reset
    input wire core_clk_i,
    input wire rst_n_i,
    // Bus pins
    input wire bus_clock_pin_i,
    input wire bus_data_pin_i,
    input wire bus_clock_pin_oe_o,
    input wire alert_output_pin_oe_o,
    // Straps and command port
    input wire [4:0] address_select_pin_i,
    input wire [6:0] own_addr_o,
    input wire require_pec_i,
    input wire wr_commit_o,
    input wire wr_reject_o,
    input wire pec_used_o,
    input wire nvm_store_o,
    // Faults and power
    input wire noncml_fault_i,
    input wire internal_bias_5v_ok_i,
    input wire analog_input_rail_ok_i,
    input wire power_input_rail_ok_i,
    input wire conversion_request_i,
    input wire conversion_enable_o,
    input wire programming_mode_o
);
    logic [3:0] bit_cnt_r;
    logic scl_d_r;
    logic sda_d_r;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Raw pins: the design sees them later, so the count is never late
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bit_cnt_r <= 4'hF;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= bus_clock_pin_i;
            sda_d_r <= bus_data_pin_i;
            if (sda_d_r && !bus_data_pin_i && bus_clock_pin_i) begin
                bit_cnt_r <= 4'h0;
            end else if (!scl_d_r && bus_clock_pin_i && bit_cnt_r != 4'hF) begin
                bit_cnt_r <= bit_cnt_r + 4'h1;
            end
        end
    end
    property p_addr_free; bit_cnt_r < 4'h8 |-> !bus_clock_pin_oe_o; endproperty
    a_addr_free: assert property (p_addr_free) else $error("stretch in address byte");
    property p_conv; conversion_enable_o == (conversion_request_i && internal_bias_5v_ok_i
        && analog_input_rail_ok_i && power_input_rail_ok_i); endproperty
    a_conv: assert property (p_conv) else $error("conversion enable wrong");
    property p_prog; programming_mode_o == (internal_bias_5v_ok_i && analog_input_rail_ok_i
        && !power_input_rail_ok_i); endproperty
    a_prog: assert property (p_prog) else $error("programming mode wrong");
    property p_addr; rst_n_i && $past(rst_n_i) |->
        own_addr_o == 7'h10 + {2'b00, address_select_pin_i}; endproperty
    a_addr: assert property (p_addr) else $error("own address wrong");
    property p_nvm; nvm_store_o |-> wr_commit_o; endproperty
    a_nvm: assert property (p_nvm) else $error("store without commit");
    property p_reject; wr_reject_o |-> require_pec_i && !wr_commit_o; endproperty
    a_reject: assert property (p_reject) else $error("reject without option");
    property p_pec_off; wr_reject_o |-> ##[0:2] !pec_used_o; endproperty
    a_pec_off: assert property (p_pec_off) else $error("checksum flagged on reject");
    property p_realert; alert_output_pin_oe_o && noncml_fault_i |=> alert_output_pin_oe_o;
    endproperty
    a_realert: assert property (p_realert) else $error("alert dropped with fault");
    property p_pulse; wr_commit_o |=> !wr_commit_o [*3]; endproperty
    a_pulse: assert property (p_pulse) else $error("commit not a pulse");
    c_store: cover property (wr_commit_o && nvm_store_o);
    c_reject: cover property (wr_reject_o);
    c_alert_clr: cover property ($fell(alert_output_pin_oe_o));
endmodule
bind pmbus_target_interface pmbus_target_interface_chk u_chk (
    .core_clk_i, .rst_n_i, .bus_clock_pin_i, .bus_data_pin_i, .bus_clock_pin_oe_o,
    .alert_output_pin_oe_o, .address_select_pin_i, .own_addr_o, .require_pec_i,
    .wr_commit_o, .wr_reject_o, .pec_used_o, .nvm_store_o, .noncml_fault_i,
    .internal_bias_5v_ok_i, .analog_input_rail_ok_i, .power_input_rail_ok_i,
    .conversion_request_i, .conversion_enable_o, .programming_mode_o
);

// ### test/pmbus_host_model.sv
module pmbus_host_model (
    // Wire levels
    input wire scl_i,
    input wire sda_i,
    // Open-drain pulls and hang flag
    output logic scl_low_o,
    output logic sda_low_o,
    output logic tmo_o
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam real Q = 31.25;
    initial begin
        scl_low_o = 1'b0;
        sda_low_o = 1'b0;
        tmo_o = 1'b0;
    end
    // Release the clock and wait out any stretch, bounded
    task automatic rel_scl;
        int n;
        scl_low_o = 1'b0;
        for (n = 0; n < 4000 && scl_i !== 1'b1; n++) #5;
        if (n == 4000) tmo_o = 1'b1;
    endtask
    task automatic bit_x(input logic b, output logic r);
        sda_low_o = !b;
        #Q;
        rel_scl();
        #(2 * Q);
        r = sda_i;
        scl_low_o = 1'b1;
        #Q;
    endtask
    task automatic start;
        sda_low_o = 1'b0;
        #Q;
        rel_scl();
        #Q;
        sda_low_o = 1'b1;
        #Q;
        scl_low_o = 1'b1;
        #Q;
    endtask
    // No checksum clocks before this means no checksum
    task automatic stop;
        sda_low_o = 1'b1;
        #Q;
        rel_scl();
        #Q;
        sda_low_o = 1'b0;
        #Q;
    endtask
    task automatic wb(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(v[i], r);
        bit_x(1'b1, r);
        ack = !r;
    endtask
    task automatic rb(input logic ack, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            v[i] = r;
        end
        bit_x(!ack, r);
    endtask
endmodule

// ### test/pmbus_target_interface_tb.sv
module pmbus_target_interface_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk_i = 1'b0;
    logic rst_n_i, strap_versus_nvm_select_i, require_pec_i, byte_ready_i, rd_valid_i;
    logic fault_event_i, noncml_fault_i, conversion_request_i, internal_bias_5v_ok_i;
    logic analog_input_rail_ok_i, power_input_rail_ok_i, bus_clock_pin_i, bus_data_pin_i;
    logic bus_clock_pin_oe_o, bus_data_pin_oe_o, alert_output_pin_oe_o, use_strap_defaults_o;
    logic wr_commit_o, wr_reject_o, pec_used_o, pec_error_o, nvm_store_o, rd_req_o;
    logic conversion_enable_o, programming_mode_o, h_scl, h_sda, tmo;
    logic [4:0] address_select_pin_i;
    logic [6:0] own_addr_o;
    logic [7:0] wr_len_i, rd_data_i, wr_data_o;
    int fails, check_count, n_commit, n_reject, n_nvm, n_str;
    pmbus_target_interface DUT (
        .core_clk_i, .rst_n_i, .bus_clock_pin_i, .bus_clock_pin_o(), .bus_clock_pin_oe_o,
        .bus_data_pin_i, .bus_data_pin_o(), .bus_data_pin_oe_o, .alert_output_pin_o(),
        .alert_output_pin_oe_o, .address_select_pin_i, .strap_versus_nvm_select_i,
        .require_pec_i, .wr_len_i, .own_addr_o, .use_strap_defaults_o, .wr_byte_o(),
        .wr_data_o, .wr_first_o(), .byte_ready_i, .wr_commit_o, .wr_reject_o, .pec_used_o,
        .pec_error_o, .nvm_store_o, .rd_req_o, .rd_data_i, .rd_valid_i, .pec_crc_o(),
        .fault_event_i, .noncml_fault_i, .internal_bias_5v_ok_i, .analog_input_rail_ok_i,
        .power_input_rail_ok_i, .conversion_request_i, .conversion_enable_o, .programming_mode_o
    );
    pmbus_host_model host (.scl_i(bus_clock_pin_i), .sda_i(bus_data_pin_i),
        .scl_low_o(h_scl), .sda_low_o(h_sda), .tmo_o(tmo));
    // Pull-ups: a released line reads high
    assign bus_clock_pin_i = !(h_scl || bus_clock_pin_oe_o);
    assign bus_data_pin_i = !(h_sda || bus_data_pin_oe_o);
    always @(negedge core_clk_i) begin
        n_commit += int'(wr_commit_o === 1'b1);
        n_reject += int'(wr_reject_o === 1'b1);
        n_nvm += int'(nvm_store_o === 1'b1);
        n_str += int'(bus_clock_pin_oe_o === 1'b1);
    end
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] d);
        c = c ^ d;
        repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
        return c;
    endfunction
    task automatic pause;
        repeat (20) @(negedge core_clk_i);
    endtask
    task automatic t_straps;
        logic a;
        chk("own_addr", 16'h2F, 16'(own_addr_o));
        chk("strap_sel", 16'h1, 16'(use_strap_defaults_o));
        host.start();
        host.wb(8'h22, a);
        host.stop();
        pause();
        chk("nomatch_ack", 16'h0, 16'(a));
    endtask
    task automatic t_write_pec;
        logic [3:0] a;
        n_str = 0;
        byte_ready_i = 1'b0;
        // Core stalls well past the command byte; target must hold the clock meanwhile
        fork
            begin
                repeat (550) @(negedge core_clk_i);
                byte_ready_i = 1'b1;
            end
        join_none
        host.start();
        host.wb(8'h5E, a[3]);
        host.wb(8'h15, a[2]);
        host.wb(8'h5A, a[1]);
        host.wb(crc(crc(crc(8'h00, 8'h5E), 8'h15), 8'h5A), a[0]);
        host.stop();
        pause();
        chk("acks", 16'hF, 16'(a));
        chk("stretch", 16'h1, 16'(n_str > 249));
        chk("commit", 16'h1, 16'(n_commit));
        chk("store", 16'h1, 16'(n_nvm));
        chk("pec_used", 16'h1, 16'(pec_used_o));
        chk("pec_error", 16'h0, 16'(pec_error_o));
    endtask
    task automatic t_no_pec;
        logic [2:0] a;
        for (int p = 1; p >= 0; p--) begin
            require_pec_i = p[0];
            host.start();
            host.wb(8'h5E, a[2]);
            host.wb(8'h20, a[1]);
            host.wb(8'h33, a[0]);
            host.stop();
            pause();
            chk("acks", 16'h7, 16'(a));
            chk("reject", 16'h1, 16'(n_reject));
            chk("commit", 16'(2 - p), 16'(n_commit));
            chk("pec_used", 16'h0, 16'(pec_used_o));
            chk("wr_data", 16'h33, 16'(wr_data_o));
            chk("store", 16'h1, 16'(n_nvm));
        end
    endtask
    task automatic t_read;
        logic [2:0] a;
        logic [7:0] v;
        host.start();
        host.wb(8'h5E, a[2]);
        host.wb(8'h8B, a[1]);
        @(negedge core_clk_i);
        rd_valid_i = 1'b0;
        fork
            begin
                for (int i = 0; i < 5000 && rd_req_o !== 1'b1; i++) @(negedge core_clk_i);
                repeat (150) @(negedge core_clk_i);
                rd_valid_i = 1'b1;
            end
        join_none
        n_str = 0;
        host.start();
        host.wb(8'h5F, a[0]);
        host.rb(1'b0, v);
        host.stop();
        pause();
        chk("acks", 16'h7, 16'(a));
        chk("rd_data", 16'hC3, 16'(v));
        chk("rd_stretch", 16'h1, 16'(n_str > 139));
    endtask
    task automatic t_ara;
        logic a;
        logic [7:0] v;
        for (int k = 0; k < 2; k++) begin
            noncml_fault_i = k[0];
            @(negedge core_clk_i) fault_event_i = 1'b1;
            @(negedge core_clk_i) fault_event_i = 1'b0;
            pause();
            chk("alert_set", 16'h1, 16'(alert_output_pin_oe_o));
            host.start();
            host.wb(8'h19, a);
            host.rb(1'b0, v);
            host.stop();
            pause();
            chk("ara_ack", 16'h1, 16'(a));
            chk("ara_addr", 16'h5E, 16'(v));
            chk("alert_after", 16'(k), 16'(alert_output_pin_oe_o));
        end
        noncml_fault_i = 1'b0;
    endtask
    task automatic t_power;
        for (int i = 0; i < 16; i++) begin
            @(negedge core_clk_i);
            {conversion_request_i, internal_bias_5v_ok_i, analog_input_rail_ok_i,
                power_input_rail_ok_i} = i[3:0];
            #1;
            chk("conv_en", 16'(&i[3:0]), 16'(conversion_enable_o));
            chk("prog_mode", 16'(i[2] & i[1] & !i[0]), 16'(programming_mode_o));
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge tmo) begin
        $display("CHECK FAILED scl_release expected 1 seen 0");
        fails++;
        complete_run();
    end
    initial forever #5 core_clk_i = !core_clk_i;
    initial begin
        rst_n_i = 1'b0;
        address_select_pin_i = 5'h1F;
        {strap_versus_nvm_select_i, byte_ready_i, rd_valid_i} = 3'h7;
        {require_pec_i, fault_event_i, noncml_fault_i, conversion_request_i} = 4'h0;
        {internal_bias_5v_ok_i, analog_input_rail_ok_i, power_input_rail_ok_i} = 3'h7;
        wr_len_i = 8'h02;
        rd_data_i = 8'hC3;
        repeat (8) @(negedge core_clk_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge core_clk_i);
        t_straps();
        t_write_pec();
        t_no_pec();
        t_read();
        t_ara();
        t_power();
        complete_run();
    end
    initial begin
        #500us;
        $display("CHECK FAILED run_time expected done seen hang");
        fails++;
        complete_run();
    end
endmodule
